// [hdl/wtqw_pkg.sv]
//------------------------------------------------------------
// Shared constants and types of the windowed watchdog.
//------------------------------------------------------------
package wtqw_pkg;
   localparam int CLK_NS = 20; // System clock period in ns.
   localparam int STEP_NS = 550000; // Watchdog time step in ns.
   localparam int STEP_CYC = STEP_NS / CLK_NS; // Step length in cycles.
   localparam int PULSE_US = 32; // Deglitch time in us.
   localparam int PULSE_CYC = (PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam logic [6:0] WIN1_RESET = 7'h08; // Default first window steps.
   localparam logic [4:0] WIN2_RESET = 5'h07; // Default second window steps.
   localparam logic [2:0] FAIL_INIT = 3'h5; // Fail tally load value.
   localparam logic [2:0] FAIL_MAX = 3'h7; // Fail tally ceiling.
   localparam logic [2:0] FAIL_OUT = 3'h5; // First out-of-range value.
   localparam logic [1:0] ANS_FIRST = 2'h3; // First expected answer index.
   localparam logic [1:0] ANS_LAST = 2'h0; // Final answer index.

   // Operating state of the surrounding device, Gray coded.
   typedef enum logic [1:0] {
      DEV_RESET = 2'b00,
      DEV_DIAG = 2'b01,
      DEV_ACTIVE = 2'b11,
      DEV_SAFE = 2'b10
   } wtqw_dev_e;

   // Window phase of the running sequence.
   typedef enum logic {
      PH_WIN1 = 1'b0,
      PH_WIN2 = 1'b1
   } wtqw_phase_e;

   // One write to the window length registers.
   typedef struct packed {
      logic win1_wr;
      logic win2_wr;
      logic [6:0] first_window_steps;
      logic [4:0] second_steps;
   } wtqw_cfg_s;

   // One answer byte write, already compared against its reference.
   typedef struct packed {
      logic valid;
      logic match;
   } wtqw_ans_s;

   // Status view of the watchdog.
   typedef struct packed {
      logic [2:0] fail_tally;
      logic [1:0] ans_cnt;
      logic answer_err;
      logic sequence_expired_flag;
      logic premature_trigger_flag;
   } wtqw_stat_s;
endpackage : wtqw_pkg

// [hdl/wtqw_watchdog.sv]
//------------------------------------------------------------
//------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module wtqw_watchdog #(
   parameter int STEP_CYCLES = wtqw_pkg::STEP_CYC
) (
   input wire logic clk, // System clock.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire wtqw_pkg::wtqw_dev_e dev_state, // Device operating state.
   input wire wtqw_pkg::wtqw_cfg_s cfg, // Window register writes.
   input wire logic config_write_lock_cmd, // Blocks window updates.
   input wire logic qa_wr, // Write of the setup register.
   input wire logic qa_select_bit, // Question mode select value.
   input wire logic fail_reset_allow, // Lets the watchdog force reset.
   input wire logic enable_drive_req, // Software enable request.
   input wire logic error_trigger_input_pin, // Trigger pin.
   input wire logic spi_cs_n_pin, // SPI chip select pin, active low.
   input wire wtqw_pkg::wtqw_ans_s ans, // Answer byte write.
   input wire logic status_clear, // Clears the sticky flags.
   output wtqw_pkg::wtqw_stat_s stat, // Status of the watchdog.
   output logic qa_mode, // High in question mode.
   output logic power_stage_enable_out, // Enable drive output.
   output logic mcu_reset_out // One-cycle reset request.
);
   import wtqw_pkg::*;

   //------------------------------------------------------------
   // Pin synchronisers and trigger deglitch
   //------------------------------------------------------------
   logic [2:0] trig_sync;
   logic [2:0] cs_sync;
   logic trig_lvl;
   logic cs_idle;
   logic [10:0] glitch_cnt;
   logic trig_filt;
   logic trig_fall;
   wire trig_diff = trig_sync[2] == trig_sync[1] && trig_sync[1] != trig_lvl;
   wire glitch_done = glitch_cnt == 11'(PULSE_CYC - 1);
   wire trig_flip = trig_lvl != trig_filt && glitch_done;

   // Three-stage capture; a level counts once stages two and three agree.
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         trig_sync <= 3'h0;
         cs_sync <= 3'h7;
         trig_lvl <= 1'b0;
         cs_idle <= 1'b1;
      end
      else
      begin
         trig_sync <= {trig_sync[1:0], error_trigger_input_pin};
         cs_sync <= {cs_sync[1:0], spi_cs_n_pin};
         if (trig_diff)
            trig_lvl <= trig_sync[1];
         if (cs_sync[2] == cs_sync[1])
            cs_idle <= cs_sync[1];
      end

   // The filtered level follows only after a steady pulse time.
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         glitch_cnt <= 11'h000;
         trig_filt <= 1'b0;
         trig_fall <= 1'b0;
      end
      else
      begin
         glitch_cnt <= (trig_lvl != trig_filt && !glitch_done) ? glitch_cnt + 11'h001 : 11'h000;
         if (trig_flip)
            trig_filt <= trig_lvl;
         trig_fall <= trig_flip && trig_filt;
      end

   //------------------------------------------------------------
   // Window settings and mode
   //------------------------------------------------------------
   logic [6:0] win1_setting;
   logic [4:0] win2_setting;
   logic [6:0] act_w1;
   logic [4:0] act_w2;
   wtqw_dev_e prev_state;
   logic restart;
   wire run = dev_state != DEV_RESET;
   wire pwr_up = prev_state == DEV_RESET && dev_state == DEV_DIAG;
   wire pwr_dn = prev_state != DEV_RESET && dev_state == DEV_RESET;
   wire activate = prev_state == DEV_DIAG && dev_state == DEV_ACTIVE;
   wire cfg_open = dev_state == DEV_DIAG && !config_write_lock_cmd;
   wire cfg_ev = run && (cfg.win1_wr || cfg.win2_wr);
   wire [6:0] next_w1 = pwr_up ? WIN1_RESET
      : (cfg_open && cfg.win1_wr) ? cfg.first_window_steps : win1_setting;
   wire [4:0] next_w2 = pwr_up ? WIN2_RESET
      : (cfg_open && cfg.win2_wr) ? cfg.second_steps : win2_setting;

   // Settings, mode select and the lengths of the running sequence.
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         win1_setting <= WIN1_RESET;
         win2_setting <= WIN2_RESET;
         act_w1 <= WIN1_RESET;
         act_w2 <= WIN2_RESET;
         prev_state <= DEV_RESET;
         qa_mode <= 1'b0;
      end
      else
      begin
         prev_state <= dev_state;
         win1_setting <= next_w1;
         win2_setting <= next_w2;
         if (restart)
         begin
            act_w1 <= next_w1;
            act_w2 <= next_w2;
         end
         if (pwr_up)
            qa_mode <= 1'b0;
         else if (dev_state == DEV_DIAG && qa_wr)
            qa_mode <= qa_select_bit;
      end

   //------------------------------------------------------------
   // Sequence timing in watchdog steps
   //------------------------------------------------------------
   logic [14:0] step_cnt;
   logic [6:0] win_cnt;
   wtqw_phase_e phase;
   wire step_tick = step_cnt == 15'(STEP_CYCLES - 1);
   wire w1_end = step_tick && ({1'b0, win_cnt} + 8'h01 >= {1'b0, act_w1});
   wire w2_end = step_tick && win_cnt == {2'b00, act_w2};

   //------------------------------------------------------------
   // Event decode
   //------------------------------------------------------------
   logic [1:0] ans_cnt;
   logic answer_err;
   wire trig_ev = run && !qa_mode && trig_fall;
   wire ans_ev = run && qa_mode && ans.valid;
   wire qa_last = ans_ev && ans_cnt == ANS_LAST;
   wire err_any = answer_err || !ans.match;
   wire bad = (trig_ev && phase == PH_WIN1)
      || (qa_last && (err_any || phase == PH_WIN1));
   wire good = (trig_ev && phase == PH_WIN2)
      || (qa_last && !err_any && phase == PH_WIN2);
   wire timeout = run && phase == PH_WIN2 && w2_end && !good && !bad;
   assign restart = good || bad || timeout || cfg_ev || pwr_up || pwr_dn;

   // Step counter and window phase; a restart takes effect next cycle.
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         step_cnt <= 15'h0000;
         win_cnt <= 7'h00;
         phase <= PH_WIN1;
      end
      else if (restart || !run)
      begin
         step_cnt <= 15'h0000;
         win_cnt <= 7'h00;
         phase <= PH_WIN1;
      end
      else
      begin
         step_cnt <= step_tick ? 15'h0000 : step_cnt + 15'h0001;
         if (phase == PH_WIN1 && w1_end)
         begin
            phase <= PH_WIN2;
            win_cnt <= 7'h00;
         end
         else if (step_tick)
            win_cnt <= win_cnt + 7'h01;
      end

   // Answer byte count and error memory of the current sequence.
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         ans_cnt <= ANS_FIRST;
         answer_err <= 1'b0;
      end
      else if (restart)
      begin
         ans_cnt <= ANS_FIRST;
         answer_err <= 1'b0;
      end
      else if (ans_ev)
      begin
         ans_cnt <= ans_cnt - 2'h1;
         answer_err <= err_any;
      end

   //------------------------------------------------------------
   // Fail tally, flags and outputs
   //------------------------------------------------------------
   logic [2:0] fail_tally;
   logic expired;
   logic premature;
   wire inc_ev = bad || timeout || cfg_ev;
   wire [2:0] next_tally = (pwr_up || activate) ? FAIL_INIT
      : inc_ev ? ((fail_tally == FAIL_MAX) ? FAIL_MAX : fail_tally + 3'h1)
      : (good && fail_tally != 3'h0) ? fail_tally - 3'h1 : fail_tally;
   wire rst_hit = fail_reset_allow && fail_tally == FAIL_MAX && (bad || timeout);

   // Tally and sticky flags; a setting event wins over a clear.
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         fail_tally <= FAIL_INIT;
         expired <= 1'b0;
         premature <= 1'b0;
      end
      else
      begin
         fail_tally <= next_tally;
         expired <= (timeout && cs_idle) || (expired && !status_clear);
         premature <= (trig_ev && phase == PH_WIN1) || (premature && !status_clear);
      end

   // Enable drive and reset request are registered.
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
      begin
         power_stage_enable_out <= 1'b0;
         mcu_reset_out <= 1'b0;
      end
      else
      begin
         power_stage_enable_out <= enable_drive_req && next_tally < FAIL_OUT;
         mcu_reset_out <= rst_hit;
      end

   assign stat = '{fail_tally: fail_tally, ans_cnt: ans_cnt, answer_err: answer_err,
      sequence_expired_flag: expired, premature_trigger_flag: premature};

   //------------------------------------------------------------
   // Assertions and covers
   //------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_cfg_restart: assert property (cfg_ev && !pwr_dn
      |=> phase == PH_WIN1 && win_cnt == 7'h00)
      else $error("Window write did not restart the sequence.");
   a_new_len: assert property (cfg_open && cfg.win1_wr && run
      |=> act_w1 == $past(cfg.first_window_steps))
      else $error("New first window length not applied.");
   a_pwrup_mode: assert property (pwr_up
      |=> !qa_mode && fail_tally == FAIL_INIT && act_w1 == WIN1_RESET)
      else $error("Power-up did not default the watchdog.");
   a_early_bad: assert property (trig_ev && phase == PH_WIN1
      |=> premature && phase == PH_WIN1)
      else $error("Early trigger not flagged.");
   a_good_dec: assert property (good && !inc_ev && !activate && fail_tally != 3'h0
      |=> fail_tally == $past(fail_tally) - 3'h1)
      else $error("Good event did not decrement the tally.");
   a_timeout_flag: assert property (timeout && cs_idle |=> expired)
      else $error("Time-out flag not set.");
   a_cs_block: assert property (timeout && !cs_idle && !expired |=> !expired)
      else $error("Time-out flag set during an SPI frame.");
   a_tally_sat: assert property (fail_tally == FAIL_MAX && inc_ev && !activate && !pwr_up
      |=> fail_tally == FAIL_MAX)
      else $error("Tally passed its ceiling.");
   a_range_drive: assert property (fail_tally >= FAIL_OUT |-> !power_stage_enable_out)
      else $error("Enable drive high while out of range.");
   a_qa_good: assert property (qa_last && !err_any && phase == PH_WIN2
      |=> ans_cnt == ANS_FIRST)
      else $error("Good answer did not restart the answer count.");
   a_deglitch: assert property ($rose(trig_filt) |-> $past(trig_lvl, 2) && trig_lvl)
      else $error("Trigger filter passed a short pulse.");

   c_good: cover property (good && !qa_mode);
   c_qa_good: cover property (good && qa_mode);
   c_timeout: cover property (timeout);
   c_reset: cover property (mcu_reset_out);
endmodule : wtqw_watchdog
`default_nettype wire

// [verif/wtqw_mcu_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Microcontroller side: trigger pulses and answer byte frames.
// ------------------------------------------------------------
module wtqw_mcu_model
(
   input wire logic clk, // System clock.
   output logic trig_pin, // Trigger pin drive.
   output logic cs_n, // Chip select, active low.
   output wtqw_pkg::wtqw_ans_s ans // Answer byte write.
);
   import wtqw_pkg::*;

   // Idle levels: pin low and no frame open.
   initial
   begin
      trig_pin = 1'b0;
      cs_n = 1'b1;
      ans = '0;
   end

   // Waits, then sends one pulse whose high time exceeds the filter time.
   task automatic trig(input int lead, input int hold);
      repeat (lead) @(negedge clk);
      trig_pin = 1'b1;
      repeat (hold) @(negedge clk);
      trig_pin = 1'b0;
   endtask : trig

   // Writes one answer byte inside a frame of its own; match flips once released.
   task automatic answer(input logic ok);
      @(negedge clk);
      cs_n = 1'b0;
      @(negedge clk);
      ans = '{valid: 1'b1, match: ok};
      @(negedge clk);
      ans = '{valid: 1'b0, match: ~ok};
      cs_n = 1'b1;
   endtask : answer

   // Keeps a frame open for a number of cycles.
   task automatic frame(input int len);
      cs_n = 1'b0;
      repeat (len) @(negedge clk);
      cs_n = 1'b1;
   endtask : frame
endmodule : wtqw_mcu_model
`default_nettype wire

// [verif/wtqw_watchdog_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module wtqw_watchdog_tb;
   import wtqw_pkg::*;
   // ------------------------------------------------------------
   // Signals, notes and instances.
   // ------------------------------------------------------------
   localparam int STEPS = 350; // Short step keeps the run brief.
   localparam int SEQ = 20 * STEPS; // Sequence with settings 10 and 9.
   typedef struct {logic [2:0] t; logic e; logic p; logic r; int w;} wtqw_note_s;
   logic clk, arst_n, lock, qa_wr, qa_sel, allow, en_req, clr, pin, cs_n;
   logic qa_mode, en_out, rst_req;
   logic [2:0] prev;
   wtqw_dev_e dev;
   wtqw_cfg_s cfg;
   wtqw_ans_s ans;
   wtqw_stat_s stat;
   wtqw_note_s notes[$];
   int errors = 0, num_checks = 0, cyc = 0, last = 0;

   wtqw_watchdog #(.STEP_CYCLES(STEPS)) wtqw_watchdog_inst (.clk(clk), .arst_n(arst_n),
      .dev_state(dev), .cfg(cfg), .config_write_lock_cmd(lock), .qa_wr(qa_wr),
      .qa_select_bit(qa_sel), .fail_reset_allow(allow), .enable_drive_req(en_req),
      .error_trigger_input_pin(pin), .spi_cs_n_pin(cs_n), .ans(ans), .status_clear(clr),
      .stat(stat), .qa_mode(qa_mode), .power_stage_enable_out(en_out), .mcu_reset_out(rst_req));
   wtqw_mcu_model wtqw_mcu_model_inst (.clk(clk), .trig_pin(pin), .cs_n(cs_n), .ans(ans));

   // Free running clock and cycle count.
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   // ------------------------------------------------------------
   // Compare tasks and the closing task.
   // ------------------------------------------------------------
   task automatic cmp_val(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_val

   task automatic cmp_evt(input wtqw_note_s n);
      logic [5:0] seen;
      seen = {stat.fail_tally, stat.sequence_expired_flag, stat.premature_trigger_flag, rst_req};
      num_checks++;
      if (seen !== {n.t, n.e, n.p, n.r} || (n.w != 0 && (cyc < n.w - 6 || cyc > n.w + 6)))
      begin
         errors++;
         $display("mismatch event expected %h at %0d seen %h at %0d", {n.t, n.e, n.p, n.r},
            n.w, seen, cyc);
      end
   endtask : cmp_evt

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   // Each tally change or reset request takes the oldest note off the queue.
   always @(negedge clk)
   begin
      if (arst_n && (stat.fail_tally !== prev || rst_req === 1'b1))
      begin
         if (notes.size() == 0)
            cmp_val("unexpected event", 8'h00, 8'h01);
         else
            cmp_evt(notes.pop_front());
         last = cyc;
      end
      prev = stat.fail_tally;
   end

   // ------------------------------------------------------------
   // Driver helpers.
   // ------------------------------------------------------------
   task automatic note(input logic [2:0] t, input logic e, p, r, input int w);
      notes.push_back('{t, e, p, r, w});
   endtask : note

   task automatic wait_q(input int lim);
      int n;
      n = 0;
      while (notes.size() != 0 && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      if (notes.size() != 0)
      begin
         errors++;
         $display("mismatch pending events expected 0 seen %0d", notes.size());
         notes.delete();
      end
   endtask : wait_q

   task automatic pulse_clr();
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
   endtask : pulse_clr

   task automatic wr_cfg(input logic [6:0] w1, input logic [4:0] w2);
      cfg = '{1'b1, 1'b1, w1, w2};
      @(negedge clk);
      cfg = '{1'b0, 1'b0, ~w1, ~w2};
   endtask : wr_cfg

   // Three answer bytes early in the sequence, the final one in the second window.
   task automatic qa_seq(input logic [3:0] ok);
      for (int i = 3; i >= 0; i--)
      begin
         repeat (i == 0 ? 3800 : 100) @(negedge clk);
         wtqw_mcu_model_inst.answer(ok[i]);
         // After three bytes the count stands at its last index with the errors so far.
         if (i == 1)
            cmp_val("answer status", {5'h00, 2'h0, ~&ok[3:1]},
               {5'h00, stat.ans_cnt, stat.answer_err});
      end
   endtask : qa_seq

   // Watchdog on the whole run.
   initial
   begin
      repeat (90000) @(posedge clk);
      errors++;
      close_out();
   end

   // ------------------------------------------------------------
   // Main sequence, driven at the falling edge.
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(32'ha407));
      {arst_n, lock, qa_wr, qa_sel, allow, clr} = 6'h00;
      en_req = 1'b1;
      dev = DEV_RESET;
      cfg = '0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      cmp_val("reset status", {3'h5, 2'h3, 3'h0}, stat);
      cmp_val("reset outputs", 8'h00, {5'h00, qa_mode, en_out, rst_req});
      prev = stat.fail_tally;
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      dev = DEV_DIAG;
      note(3'h6, 1, 0, 0, cyc + 16 * STEPS + 2);
      cmp_val("mode", 8'h00, {7'h00, qa_mode});
      wait_q(18 * STEPS);
      pulse_clr();
      note(3'h7, 0, 0, 0, 0);
      wr_cfg(7'h0a, 5'h09);
      wait_q(10);
      for (int k = 0; k < 3; k++)
      begin
         note(3'(6 - k), 0, 0, 0, 0);
         wtqw_mcu_model_inst.trig(2300 + $urandom % 200, 1700 + $urandom % 100);
         wait_q(2000);
      end
      repeat (3) @(negedge clk);
      cmp_val("enable in range", 8'h01, {7'h00, en_out});
      note(3'h5, 0, 1, 0, 0);
      wtqw_mcu_model_inst.trig(0, 1650);
      wait_q(2000);
      repeat (3) @(negedge clk);
      cmp_val("enable out of range", 8'h00, {7'h00, en_out});
      pulse_clr();
      note(3'h6, 0, 0, 0, last + SEQ);
      repeat (SEQ - 42) @(negedge clk);
      wtqw_mcu_model_inst.frame(80);
      wait_q(200);
      note(3'h7, 1, 0, 0, last + SEQ);
      wait_q(SEQ + 50);
      allow = 1'b1;
      note(3'h7, 1, 0, 1, last + SEQ);
      wait_q(SEQ + 50);
      pulse_clr();
      note(3'h5, 0, 0, 0, 0);
      dev = DEV_RESET;
      repeat (5) @(negedge clk);
      dev = DEV_DIAG;
      wait_q(20);
      qa_sel = 1'b1;
      qa_wr = 1'b1;
      @(negedge clk);
      qa_wr = 1'b0;
      repeat (3) @(negedge clk);
      cmp_val("question mode", 8'h01, {7'h00, qa_mode});
      note(3'h6, 0, 0, 0, 0);
      wr_cfg(7'h0a, 5'h09);
      wait_q(10);
      note(3'h5, 0, 0, 0, 0);
      qa_seq(4'hf);
      wait_q(20);
      note(3'h6, 0, 0, 0, 0);
      qa_seq(4'hb);
      wait_q(20);
      note(3'h5, 0, 0, 0, 0);
      dev = DEV_ACTIVE;
      wait_q(20);
      lock = 1'b1;
      note(3'h6, 0, 0, 0, 0);
      wr_cfg(7'h01, 5'h00);
      wait_q(10);
      note(3'h7, 1, 0, 0, last + SEQ);
      wait_q(SEQ + 50);
      close_out();
   end
endmodule : wtqw_watchdog_tb
`default_nettype wire
